// *** pkg/cpw_pkg.sv ***
// Constants shared by the complementary PWM output stage and its dead-time unit.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package cpw_pkg;
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  ADDR_GEN       = 8'h00;
    localparam logic [7:0]  ADDR_OUT       = 8'h04;
    localparam logic [7:0]  ADDR_DUTY      = 8'h08;
    localparam logic [7:0]  ADDR_MDUTY     = 8'h0c;
    localparam logic [7:0]  ADDR_PHASE     = 8'h10;
    localparam logic [7:0]  ADDR_MPER      = 8'h14;
    localparam logic [7:0]  ADDR_DT        = 8'h18;
    localparam logic [7:0]  ADDR_STAT      = 8'h1c;

    localparam int          GEN_IMM_BIT    = 0;
    localparam int          GEN_CENTER_BIT = 2;
    localparam int          GEN_DSEL_BIT   = 8;
    localparam int          GEN_ITB_BIT    = 9;
    localparam int          GEN_EN_BIT     = 15;

    localparam int          OUT_SYNC_BIT   = 0;
    localparam int          OUT_OVD_L_BIT  = 6;
    localparam int          OUT_OVD_H_BIT  = 7;
    localparam int          OUT_OVE_L_BIT  = 8;
    localparam int          OUT_OVE_H_BIT  = 9;
    localparam int          OUT_MODE_LSB   = 10;

    localparam int          STAT_H_BIT     = 16;
    localparam int          STAT_L_BIT     = 17;
    localparam int          STAT_PP_BIT    = 18;

    localparam logic [1:0]  MODE_COMPL     = 2'h0;
    localparam logic [1:0]  MODE_REDUN     = 2'h1;
    localparam logic [1:0]  MODE_PUSHPULL  = 2'h2;

    localparam logic [15:0] RST_GEN        = 16'h0000;
    localparam logic [15:0] RST_OUT        = 16'h0000;
    localparam logic [15:0] RST_DUTY       = 16'h0000;
    localparam logic [15:0] RST_PERIOD     = 16'h00ff;
    localparam logic [15:0] RST_DT         = 16'h0000;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        CPW_IDLE = 2'h1,
        CPW_RESP = 2'h2
    } cpw_bus_st_t;
endpackage

// *** design/cpw_deadtime.sv ***
// Dead-time unit: turns the requested high/low levels into the output pair.
// Assumes requests come from flops on the same clock.
`timescale 1ns/1ps
module cpw_deadtime #(
    parameter int W = 16
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         dt_en,
    input  wire logic         req_h,
    input  wire logic         req_l,
    input  wire logic [W-1:0] dead_time,
    output logic              out_h,
    output logic              out_l
);
    import cpw_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         h;
        logic         l;
    } cpw_dt_st_t;

    cpw_dt_st_t s_q;
    cpw_dt_st_t s_d;
    logic       drop;

    always_comb
    begin
        s_d  = s_q;
        drop = (s_q.h && !req_h) || (s_q.l && !req_l);
        if (!dt_en)
        begin
            s_d.h   = req_h;
            s_d.l   = req_l;
            s_d.cnt = '0;
        end
        else if (drop)
        begin
            // Deassert at once, then hold both off for the programmed count
            if (!req_h)
                s_d.h = 1'b0;
            if (!req_l)
                s_d.l = 1'b0;
            s_d.cnt = dead_time;
        end
        else if (s_q.cnt != '0)
            s_d.cnt = s_q.cnt - 1'b1;
        else if (req_h && !s_q.l)
            s_d.h = 1'b1;
        else if (req_l && !s_q.h)
            s_d.l = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign out_h = s_q.h;
    assign out_l = s_q.l;
endmodule

// *** design/cpw_output_stage.sv ***
// Complementary PWM output stage with AXI4-Lite control registers.
// Assumes a single clock; the gate drivers sample the output pair.
`timescale 1ns/1ps
import cpw_pkg::*;

module cpw_output_stage #(
    parameter int W = 16
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [cpw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [cpw_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic                           pwm_high_out,
    output logic                           pwm_low_out
);
    import cpw_pkg::*;

    typedef struct packed {
        cpw_bus_st_t       wst;
        logic              have_aw;
        logic              have_w;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic [1:0]        bresp;
        cpw_bus_st_t       rst;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [15:0]       gen;
        logic [15:0]       outc;
        logic [W-1:0]      duty;
        logic [W-1:0]      mduty;
        logic [W-1:0]      phase;
        logic [W-1:0]      mper;
        logic [W-1:0]      dtv;
        logic [W-1:0]      mcnt;
        logic              mdown;
        logic [W-1:0]      lcnt;
        logic              ldown;
        logic [W-1:0]      act_duty;
        logic              ovr_h;
        logic              ovr_l;
        logic              ovd_h;
        logic              ovd_l;
        logic              pp;
        logic              raw;
    } cpw_st_t;

    cpw_st_t     s_q;
    cpw_st_t     s_d;
    logic        req_h;
    logic        req_l;
    logic        dt_en;
    logic        out_h;
    logic        out_l;
    logic        en;
    logic        center;
    logic        bound;
    logic [W:0]  mstep;
    logic [W:0]  lstep;
    logic [W:0]  shifted;
    logic [W-1:0] cnt_sel;
    logic [W-1:0] dsrc;
    logic [1:0]  mode;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[ADDR_W-1:5] == '0);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = nw[8*i +: 8];
        merge = r;
    endfunction

    // Returns {down, count} one step ahead; a zero period parks the count at zero
    function automatic logic [W:0] step(input logic [W-1:0] c, input logic dn,
                                        input logic [W-1:0] per, input logic ctr);
        logic [W:0] r;
        r = '0;
        if (per == '0)
            r = '0;
        else if (!ctr)
            r = {1'b0, (c >= per) ? {W{1'b0}} : W'(c + 1'b1)};
        else if (!dn)
            r = (c >= per) ? {1'b1, W'(c - 1'b1)} : {1'b0, W'(c + 1'b1)};
        else
            r = (c == '0) ? {1'b0, W'(c + 1'b1)} : {1'b1, W'(c - 1'b1)};
        step = r;
    endfunction

    function automatic logic [31:0] rd_word(input cpw_st_t s, input logic [ADDR_W-1:0] a,
                                            input logic oh, input logic ol);
        logic [31:0] r;
        r = '0;
        case (a[4:2])
            3'h0: r[15:0] = s.gen;
            3'h1: r[15:0] = s.outc;
            3'h2: r[W-1:0] = s.duty;
            3'h3: r[W-1:0] = s.mduty;
            3'h4: r[W-1:0] = s.phase;
            3'h5: r[W-1:0] = s.mper;
            3'h6: r[W-1:0] = s.dtv;
            3'h7:
            begin
                r[W-1:0]     = s.gen[GEN_ITB_BIT] ? s.lcnt : s.mcnt;
                r[STAT_H_BIT] = oh;
                r[STAT_L_BIT] = ol;
                r[STAT_PP_BIT] = s.pp;
            end
            default: r = '0;
        endcase
        rd_word = r;
    endfunction

    always_comb
    begin
        s_d     = s_q;
        en      = s_q.gen[GEN_EN_BIT];
        center  = s_q.gen[GEN_CENTER_BIT];
        mode    = s_q.outc[OUT_MODE_LSB +: 2];

        // Bus handshakes
        s_axi_awready = (s_q.wst == CPW_IDLE) && !s_q.have_aw;
        s_axi_wready  = (s_q.wst == CPW_IDLE) && !s_q.have_w;
        s_axi_bvalid  = (s_q.wst == CPW_RESP);
        s_axi_arready = (s_q.rst == CPW_IDLE);
        s_axi_rvalid  = (s_q.rst == CPW_RESP);
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.have_aw = 1'b1;
            s_d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.have_w = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (s_q.wst == CPW_IDLE && s_q.have_aw && s_q.have_w)
        begin
            s_d.have_aw = 1'b0;
            s_d.have_w  = 1'b0;
            s_d.wst     = CPW_RESP;
            s_d.bresp   = mapped(s_q.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (mapped(s_q.waddr))
            begin
                // Override bits stay writable whether or not the generator runs
                case (s_q.waddr[4:2])
                    3'h0: s_d.gen   = 16'(merge({16'h0000, s_q.gen}, s_q.wdata, s_q.wstrb));
                    3'h1: s_d.outc  = 16'(merge({16'h0000, s_q.outc}, s_q.wdata, s_q.wstrb));
                    3'h2: s_d.duty  = W'(merge(32'(s_q.duty), s_q.wdata, s_q.wstrb));
                    3'h3: s_d.mduty = W'(merge(32'(s_q.mduty), s_q.wdata, s_q.wstrb));
                    3'h4: s_d.phase = W'(merge(32'(s_q.phase), s_q.wdata, s_q.wstrb));
                    3'h5: s_d.mper  = W'(merge(32'(s_q.mper), s_q.wdata, s_q.wstrb));
                    3'h6: s_d.dtv   = W'(merge(32'(s_q.dtv), s_q.wdata, s_q.wstrb));
                    default: s_d.dtv = s_q.dtv;
                endcase
            end
        end
        else if (s_q.wst == CPW_RESP && s_axi_bready)
            s_d.wst = CPW_IDLE;

        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rst   = CPW_RESP;
            s_d.rdata = mapped(s_axi_araddr) ? rd_word(s_q, s_axi_araddr, out_h, out_l) : '0;
            s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_q.rst == CPW_RESP && s_axi_rready)
            s_d.rst = CPW_IDLE;

        // Time bases; a stopped generator holds both counters at zero
        mstep = step(s_q.mcnt, s_q.mdown, s_q.mper, center);
        lstep = step(s_q.lcnt, s_q.ldown, s_q.phase, center);
        s_d.mcnt  = en ? mstep[W-1:0] : '0;
        s_d.mdown = en & mstep[W];
        s_d.lcnt  = en ? lstep[W-1:0] : '0;
        s_d.ldown = en & lstep[W];

        // Master base in edge mode is offset by the phase, wrapped at the master period
        shifted = {1'b0, s_d.mcnt} + {1'b0, s_q.phase};
        if (shifted > {1'b0, s_q.mper})
            shifted = shifted - {1'b0, s_q.mper} - 1'b1;
        if (s_q.gen[GEN_ITB_BIT])
            cnt_sel = s_d.lcnt;
        else if (!center)
            cnt_sel = shifted[W-1:0];
        else
            cnt_sel = s_d.mcnt;
        bound = (cnt_sel == '0);

        dsrc = s_q.gen[GEN_DSEL_BIT] ? s_q.mduty : s_q.duty;
        if (s_q.gen[GEN_IMM_BIT])
            s_d.act_duty = dsrc;
        else if (bound)
            s_d.act_duty = dsrc;
        // New duty and count are compared together, so zero duty gives no sliver
        s_d.raw = en && (cnt_sel < s_d.act_duty);

        if (en && bound)
            s_d.pp = ~s_q.pp;
        else if (!en)
            s_d.pp = 1'b0;

        // Override pickup: each clock, or only at the period boundary
        if (!s_q.outc[OUT_SYNC_BIT] || bound)
        begin
            s_d.ovr_h = s_q.outc[OUT_OVE_H_BIT];
            s_d.ovr_l = s_q.outc[OUT_OVE_L_BIT];
            s_d.ovd_h = s_q.outc[OUT_OVD_H_BIT];
            s_d.ovd_l = s_q.outc[OUT_OVD_L_BIT];
        end

        case (mode)
            MODE_REDUN:
            begin
                req_h = s_q.raw;
                req_l = s_q.raw;
            end
            MODE_PUSHPULL:
            begin
                req_h = s_q.raw && !s_q.pp;
                req_l = s_q.raw && s_q.pp;
            end
            default:
            begin
                req_h = s_q.raw;
                req_l = en && !s_q.raw;
            end
        endcase
        dt_en = (mode != MODE_REDUN) && (mode != MODE_PUSHPULL);
        // Overrides feed the dead-time unit too, so a release still waits it out except in redundant and push-pull modes
        if (s_q.ovr_h)
            req_h = s_q.ovd_h;
        if (s_q.ovr_l)
            req_l = s_q.ovd_l;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q       <= '0;
            s_q.wst   <= CPW_IDLE;
            s_q.rst   <= CPW_IDLE;
            s_q.gen   <= RST_GEN;
            s_q.outc  <= RST_OUT;
            s_q.duty  <= W'(RST_DUTY);
            s_q.mduty <= W'(RST_DUTY);
            s_q.phase <= W'(RST_PERIOD);
            s_q.mper  <= W'(RST_PERIOD);
            s_q.dtv   <= W'(RST_DT);
        end
        else
            s_q <= s_d;
    end

    cpw_deadtime #(
        .W         (W)
    ) u_dt (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .dt_en     (dt_en),
        .req_h     (req_h),
        .req_l     (req_l),
        .dead_time (s_q.dtv),
        .out_h     (out_h),
        .out_l     (out_l)
    );

    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rdata  = s_q.rdata;
    assign s_axi_rresp  = s_q.rresp;
    assign pwm_high_out = out_h;
    assign pwm_low_out  = out_l;
endmodule

// *** verif/cpw_gate_model.sv ***
// Gate-driver model on the output pair: tallies rises, overlap and gaps.
// Samples the pair on the stage clock; clr restarts the tallies.
`timescale 1ns/1ps
module cpw_gate_model (
    input  wire logic        aclk,
    input  wire logic        clr,
    input  wire logic        hi,
    input  wire logic        lo,
    output logic      [15:0] n_h,
    output logic      [15:0] n_l,
    output logic      [15:0] n_both,
    output logic      [15:0] gap_min,
    output logic      [15:0] per_h
);
    logic        h_q     = 1'b0;
    logic        l_q     = 1'b0;
    logic [15:0] off_q   = 16'h0;
    logic [15:0] since_q = 16'h0;
    always @(posedge aclk)
    begin
        h_q <= hi;
        l_q <= lo;
        off_q <= (hi || lo) ? 16'h0 : off_q + 16'h1;
        since_q <= (hi && !h_q) ? 16'h1 : since_q + 16'h1;
        if (hi && !h_q)
            per_h <= since_q;
        if (clr)
        begin
            n_h <= 16'h0;
            n_l <= 16'h0;
            n_both <= 16'h0;
            gap_min <= 16'hffff;
        end
        else
        begin
            n_h <= n_h + 16'(hi && !h_q);
            n_l <= n_l + 16'(lo && !l_q);
            n_both <= n_both + 16'(hi && lo);
            // A rise straight after a sample with either output on counts as a zero gap
            if ((hi && !h_q) || (lo && !l_q))
                gap_min <= (off_q < gap_min) ? off_q : gap_min;
        end
    end
endmodule

// *** verif/cpw_chk.sv ***
// Port checker for the PWM output stage.
// Snoops mode and dead-time writes; assumes full-word writes only.
`timescale 1ns/1ps
module cpw_chk
    import cpw_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pwm_high_out,
    input wire logic        pwm_low_out
);
    logic [1:0]   mode_q;
    logic [W-1:0] dt_q;
    logic [W-1:0] gap_q;
    logic         wr_go;
    logic         compl;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign compl = mode_q == MODE_COMPL || mode_q == 2'h3;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= MODE_COMPL;
            dt_q <= '0;
        end
        else if (wr_go && s_axi_awaddr == ADDR_OUT)
            mode_q <= s_axi_wdata[11:10];
        else if (wr_go && s_axi_awaddr == ADDR_DT)
            dt_q <= s_axi_wdata[W-1:0];
    end
    // Saturates so a long idle never wraps back to a short gap
    always_ff @(posedge aclk)
    begin
        if (!aresetn || pwm_high_out || pwm_low_out)
            gap_q <= '0;
        else if (gap_q != '1)
            gap_q <= gap_q + 1'b1;
    end
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_B_LAT: assert property (wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles after the transfer");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while a response waits");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after the address");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_DT_LOW: assert property (compl && $rose(pwm_low_out) |-> gap_q > dt_q)
        else $error("low output rose inside the dead time");
    AST_DT_HIGH: assert property (compl && $rose(pwm_high_out) |-> gap_q > dt_q)
        else $error("high output rose inside the dead time");
    AST_NO_SHOOT: assert property (compl |-> !(pwm_high_out && pwm_low_out))
        else $error("both outputs high in complementary mode");
endmodule
bind cpw_output_stage cpw_chk #(.W(W)) u_cpw_chk (.*);

// *** verif/complementary_pwm_output_stage_test.sv ***
// Bench for the PWM output stage: AXI4-Lite tasks and checked sequences.
// Assumes the gate model and the bound checker are compiled first.
`timescale 1ns/1ps
module complementary_pwm_output_stage_test;
    import cpw_pkg::*;
    logic        aclk, aresetn, clr;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, pwm_high_out, pwm_low_out;
    logic [15:0] n_h, n_l, n_both, gap_min, per_h;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;
    cpw_output_stage u_cpw_output_stage (.*);
    cpw_gate_model u_cpw_gate_model (.aclk(aclk), .clr(clr), .hi(pwm_high_out),
        .lo(pwm_low_out), .n_h(n_h), .n_l(n_l), .n_both(n_both), .gap_min(gap_min),
        .per_h(per_h));
    always #25 aclk = ~aclk;
    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run is under two thousand cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic clear();
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
    endtask
    task automatic wait_h(input logic v);
        do @(posedge aclk); while (pwm_high_out !== v);
    endtask
    // Ready waits one cycle after valid so the held-response checks see a stall
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        logic b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b)
        begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1)
            begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1)
            begin
                b = s_axi_bready;
                s_axi_bready <= !b;
            end
        end
        chk("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ar;
        logic got;
        ar = 1'b1;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (ar && s_axi_arready === 1'b1)
            begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1)
            begin
                got = s_axi_rready;
                s_axi_rready <= !got;
            end
        end
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    task automatic per_chk(input logic [15:0] e);
        cyc(40);
        wait_h(1'b0);
        wait_h(1'b1);
        cyc(1);
        chk("period", 32'(per_h), 32'(e));
    endtask
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        cyc(20);
        aresetn <= 1'b1;
        cyc(1);
        rd(ADDR_GEN, 32'h0, RESP_OKAY);
        rd(ADDR_MPER, 32'h00ff, RESP_OKAY);
        rd(ADDR_DT, 32'h0, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(ADDR_MPER, 32'hf);
        wr(ADDR_PHASE, 32'h0);
        wr(ADDR_DUTY, 32'h8);
        wr(ADDR_DT, 32'h2);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_GEN, 32'h0);
            wr(ADDR_OUT, 32'(m) << 10);
            wr(ADDR_GEN, 32'h8000);
            wait_h(1'b0);
            wait_h(1'b1);
            clear();
            cyc(61);
            chk("high rises", 32'(n_h), (m == 2) ? 1 : 3);
            chk("low rises", 32'(n_l), (m == 1) ? 3 : (m == 2) ? 2 : 4);
            chk("overlap", 32'(n_both != 0), 32'(m == 1));
            if (m == 0 || m == 3)
                chk("gap", 32'(gap_min), 32'h3);
        end
        for (int m = 1; m < 3; m++)
        begin
            wr(ADDR_OUT, 32'(m) << 10);
            wr(ADDR_DUTY, 32'h8);
            wait_h(1'b1);
            wait_h(1'b0);
            clear();
            wr(ADDR_DUTY, 32'h0);
            cyc(40);
            chk("rises after zero duty", 32'(n_h + n_l), 32'h0);
        end
        wr(ADDR_GEN, 32'h8001);
        wr(ADDR_DUTY, 32'he);
        wait_h(1'b0);
        wait_h(1'b1);
        wr(ADDR_DUTY, 32'h0);
        cyc(3);
        chk("high after immediate zero", 32'(pwm_high_out), 32'h0);
        wr(ADDR_OUT, 32'h400);
        wr(ADDR_DUTY, 32'h8);
        wr(ADDR_GEN, 32'h8100);
        cyc(20);
        clear();
        cyc(40);
        chk("rises on zero master duty", 32'(n_h), 32'h0);
        wr(ADDR_MDUTY, 32'h8);
        cyc(24);
        chk("rises on master duty", 32'(n_h != 0), 32'h1);
        wr(ADDR_DUTY, 32'h4);
        wr(ADDR_PHASE, 32'h7);
        wr(ADDR_GEN, 32'h8200);
        per_chk(16'h8);
        wr(ADDR_GEN, 32'h8000);
        per_chk(16'h10);
        wr(ADDR_GEN, 32'h0);
        wr(ADDR_OUT, 32'h0);
        wr(ADDR_DUTY, 32'h8);
        wr(ADDR_GEN, 32'h8000);
        clear();
        wr(ADDR_PHASE, 32'h1);
        cyc(40);
        wr(ADDR_PHASE, 32'hc);
        cyc(40);
        wr(ADDR_GEN, 32'h8004);
        cyc(80);
        chk("dead time", 32'(gap_min), 32'h3);
        chk("overlap", 32'(n_both), 32'h0);
        wr(ADDR_GEN, 32'h8000);
        wr(ADDR_DUTY, 32'hf);
        wait_h(1'b0);
        wait_h(1'b1);
        wr(ADDR_OUT, 32'h340);
        cyc(7);
        chk("forced pair", {30'h0, pwm_high_out, pwm_low_out}, 32'h1);
        clear();
        cyc(40);
        chk("rises while forced", 32'(n_h), 32'h0);
        clear();
        wr(ADDR_OUT, 32'h0);
        cyc(40);
        chk("gap after release", 32'(gap_min), 32'h3);
        wr(ADDR_GEN, 32'h0);
        cyc(4);
        chk("stopped pair", {30'h0, pwm_high_out, pwm_low_out}, 32'h0);
        wr(ADDR_OUT, 32'h300);
        rd(ADDR_OUT, 32'h300, RESP_OKAY);
        rd(ADDR_STAT, 32'h0, RESP_OKAY);
        give_verdict();
    end
endmodule
